/* File: testbench/bic_branch_it_ctrl_chk.sv */
`timescale 1ns/100ps
`default_nettype none
`include "bic_params.svh"
module bic_branch_it_ctrl_chk
    import bic_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire bic_instr_type instr,
    input wire logic exc_take,
    input wire logic exc_resume,
    input wire bic_it_type it_restore,
    input wire bic_it_type it_saved,
    input wire bic_result_type result,
    input wire logic it_active
);
    // Accepted instruction with no block in progress
    wire logic go = instr.valid && !exc_take && !exc_resume && !it_active;
    wire logic ind = instr.op inside {BIC_OP_BRANCH_INDIRECT, BIC_OP_BRANCH_INDIRECT_LINK};
    function automatic logic [2:0] slots(input logic [3:0] m);
        return m[0] ? 3'h4 : m[1] ? 3'h3 : m[2] ? 3'h2 : 3'h1;
    endfunction
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_link;
        go && instr.op == BIC_OP_BRANCH_LINK_IMM |=> result.link_we
            && result.link_value == $past(instr.next_pc);
    endproperty
    a_link: assert property (p_link) else $error("link value wrong");
    property p_fault;
        go && ind && !instr.reg_value[0] |=> result.fault && !result.taken;
    endproperty
    a_fault: assert property (p_fault) else $error("missing usage fault");
    property p_dest;
        go && ind && instr.reg_value[0] |=> result.taken
            && result.target == {$past(instr.reg_value[31:1]), 1'b0};
    endproperty
    a_dest: assert property (p_dest) else $error("indirect target wrong");
    property p_near;
        go && instr.op == BIC_OP_BRANCH_COND
            && $signed(instr.offset) > $signed(`BIC_NEAR_REACH) |=> !result.taken;
    endproperty
    a_near: assert property (p_near) else $error("near reach exceeded");
    property p_cz;
        go && instr.op inside {BIC_OP_COMPARE_ZERO_JUMP, BIC_OP_COMPARE_NONZERO_JUMP}
            && instr.offset >= `BIC_CZ_MIN && instr.offset <= `BIC_CZ_MAX
            |=> result.taken == (($past(instr.op) == BIC_OP_COMPARE_ZERO_JUMP)
            == ($past(instr.reg_value) == 32'h0));
    endproperty
    a_cz: assert property (p_cz) else $error("compare jump wrong");
    property p_len;
        go && instr.op == BIC_OP_IF_THEN_PREFIX |=> it_active
            && it_saved.count == slots($past(instr.it_mask));
    endproperty
    a_len: assert property (p_len) else $error("block length wrong");
    property p_hold;
        exc_take && !exc_resume |=> !result.valid && it_saved == $past(it_saved);
    endproperty
    a_hold: assert property (p_hold) else $error("state lost on exception");
    property p_res;
        exc_resume |=> it_saved == $past(it_restore);
    endproperty
    a_res: assert property (p_res) else $error("resume state wrong");
endmodule // bic_branch_it_ctrl_chk
bind bic_branch_it_ctrl bic_branch_it_ctrl_chk i_bic_branch_it_ctrl_chk (.clk_sys(clk_sys),
    .rst(rst), .instr(instr), .exc_take(exc_take), .exc_resume(exc_resume),
    .it_restore(it_restore), .it_saved(it_saved), .result(result), .it_active(it_active));
`default_nettype wire

/* File: testbench/bic_branch_it_ctrl_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "bic_params.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module bic_branch_it_ctrl_tb_top import bic_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] flags = 4'h0;
    logic exc_take = 1'b0;
    logic exc_resume = 1'b0;
    bic_it_type it_restore = {3'h1, 4'h1, 4'h0};
    bic_instr_type instr;
    bic_it_type it_saved;
    bic_result_type result;
    logic it_active;
    int mismatches = 0;
    int samples_checked = 0;
    integer seed = 32'h3fd6;
    logic [2:0] cnt = 3'h0;
    logic [3:0] base = 4'h0;
    logic [3:0] els = 4'h0;
    logic pv = 1'b0, px = 1'b0, pe = 1'b0, pt = 1'b0;
    logic pf = 1'b0;
    logic [32:0] plk = 33'h0;
    logic [31:0] ptg = 32'h0;
    bic_op_type ops [9] = '{BIC_OP_BRANCH_IMM, BIC_OP_BRANCH_COND, BIC_OP_BRANCH_LINK_IMM,
        BIC_OP_BRANCH_INDIRECT, BIC_OP_BRANCH_INDIRECT_LINK, BIC_OP_COMPARE_ZERO_JUMP,
        BIC_OP_COMPARE_NONZERO_JUMP, BIC_OP_IF_THEN_PREFIX, BIC_OP_OTHER};
    always #2 clk_sys = ~clk_sys;
    bic_stream_model i_bic_stream_model (.clk_sys(clk_sys), .instr(instr));
    bic_branch_it_ctrl i_bic_branch_it_ctrl (.clk_sys(clk_sys), .rst(rst), .instr(instr),
        .flags(flags), .exc_take(exc_take), .exc_resume(exc_resume), .it_restore(it_restore),
        .it_saved(it_saved), .result(result), .it_active(it_active));
    // Condition test on {n,z,c,v}; odd codes invert
    function automatic logic cok(input logic [3:0] c, input logic [3:0] f);
        logic r;
        case (c[3:1])
            3'h0: r = f[2];
            3'h1: r = f[1];
            3'h2: r = f[3];
            3'h3: r = f[0];
            3'h4: r = f[1] & ~f[2];
            3'h5: r = f[3] == f[0];
            3'h6: r = ~f[2] & (f[3] == f[0]);
            default: r = 1'b1;
        endcase
        return (c[3:1] == 3'h7) ? 1'b1 : r ^ c[0];
    endfunction
    function automatic logic exp_tk(input bic_instr_type x, input logic [3:0] f);
        case (x.op)
            BIC_OP_BRANCH_IMM, BIC_OP_BRANCH_LINK_IMM: return 1'b1;
            BIC_OP_BRANCH_COND: return cok(x.cond, f) && x.offset != (`BIC_NEAR_REACH << 2);
            BIC_OP_BRANCH_INDIRECT, BIC_OP_BRANCH_INDIRECT_LINK: return x.reg_value[0];
            BIC_OP_COMPARE_ZERO_JUMP: return x.reg_value == 32'h0;
            BIC_OP_COMPARE_NONZERO_JUMP: return x.reg_value != 32'h0;
            default: return 1'b0;
        endcase
    endfunction
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One cycle: drive, check the previous answer, then predict this one
    task automatic step(input bic_instr_type x, input logic [3:0] f, input logic [1:0] e);
        logic [31:0] pcv;
        logic ex;
        logic ind;
        @(posedge clk_sys);
        pcv = i_bic_stream_model.pc_q;
        flags <= f;
        exc_take <= e[0];
        exc_resume <= e[1];
        if (x.valid) i_bic_stream_model.offer(x); else i_bic_stream_model.idle();
        #1;
        `CHK(result.valid, pv)
        if (pv) `CHK(result.taken, pt)
        if (pv && px) `CHK(result.executed, pe)
        if (pv && pt) `CHK(result.target, ptg)
        if (pv) `CHK(result.fault, pf)
        if (pv) `CHK({result.link_we, result.link_value}, plk)
        if (pv) `CHK(result.in_block, px)
        `CHK(it_active, cnt != 3'h0)
        `CHK(it_saved, bic_it_type'((cnt == 3'h0) ? 11'h0 : {cnt, base, els}))
        pv = x.valid && e == 2'b00;
        if (e[1]) {cnt, base, els} = it_restore;
        px = cnt != 3'h0;
        pe = cok({base[3:1], base[0] ^ els[3]}, f) || x.op == BIC_OP_BREAKPOINT;
        pt = px ? pe && x.op == BIC_OP_BRANCH_COND : exp_tk(x, f);
        ex = !px || pe;
        ind = x.op inside {BIC_OP_BRANCH_INDIRECT, BIC_OP_BRANCH_INDIRECT_LINK};
        pf = ex && ind && !x.reg_value[0];
        plk = (ex && (x.op == BIC_OP_BRANCH_LINK_IMM
            || (x.op == BIC_OP_BRANCH_INDIRECT_LINK && x.reg_value[0])))
            ? {1'b1, pcv + 32'h4} : 33'h0;
        ptg = ind ? {x.reg_value[31:1], 1'b0} : pcv + x.offset;
        if (pv && px) begin
            els = els << 1;
            cnt = cnt - 3'h1;
        end else if (pv && x.op == BIC_OP_IF_THEN_PREFIX) begin
            base = x.cond;
            els = (x.cond == `BIC_COND_ALWAYS) ? 4'h0 : {1'b0, x.it_mask[3:1]};
            cnt = x.it_mask[0] ? 3'h4 : x.it_mask[1] ? 3'h3 : x.it_mask[2] ? 3'h2 : 3'h1;
        end
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        test_done();
    end
    initial begin
        bic_instr_type x;
        logic [31:0] r;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        x = '0;
        {x.valid, x.op, x.cond, x.it_mask} = {1'b1, BIC_OP_IF_THEN_PREFIX, 4'h0, 4'h4};
        step(x, 4'h0, 2'b00);
        x.valid = 1'b0;
        step(x, 4'h0, 2'b01);
        step(x, 4'h0, 2'b10);
        // Random stream; blocks hold only legal members
        for (int n = 0; n < 400; n++) begin
            r = $random(seed);
            x = '0;
            x.valid = 1'b1;
            x.reg_num = {1'b0, r[2:0]};
            x.reg_value = r[3] ? 32'h0 : $random(seed);
            x.offset = r[4] ? `BIC_CZ_MIN : `BIC_CZ_MAX;
            x.it_mask = (r[18:15] == 4'h0) ? 4'h8 : r[18:15];
            if (cnt != 3'h0) begin
                x.op = (cnt == 3'h1 && r[5]) ? BIC_OP_BRANCH_COND :
                    (r[6] ? BIC_OP_BREAKPOINT : BIC_OP_OTHER);
                x.cond = {base[3:1], base[0] ^ els[3]};
                x.offset = `BIC_NEAR_REACH << 2;
            end else begin
                x.op = ops[r[10:7] % 9];
                x.cond = (x.op inside {BIC_OP_BRANCH_COND, BIC_OP_IF_THEN_PREFIX}) ?
                    4'(r[14:11] % 14) : `BIC_COND_ALWAYS;
                if (x.op == BIC_OP_IF_THEN_PREFIX && r[25]) begin
                    x.cond = `BIC_COND_ALWAYS;
                    x.it_mask = 4'h8 >> r[16:15];
                end
                if (x.op == BIC_OP_BRANCH_COND && r[19]) x.offset = `BIC_NEAR_REACH << 2;
                if (x.op inside {BIC_OP_BRANCH_IMM, BIC_OP_BRANCH_LINK_IMM})
                    x.offset = r[20] ? `BIC_FAR_REACH - 32'sh2 : 32'sh2 - `BIC_FAR_REACH;
            end
            step(x, r[24:21], 2'b00);
        end
        test_done();
    end
endmodule // bic_branch_it_ctrl_tb_top
`default_nettype wire

/* File: testbench/bic_stream_model.sv */
`timescale 1ns/100ps
`default_nettype none
module bic_stream_model
    import bic_pkg::*;
(
    input wire logic clk_sys,
    output bic_instr_type instr
);
    logic [31:0] pc_q = 32'h0000_1000;
    initial instr = '0;
    // Caller aligns to a rising edge; fields come from the fetch address
    task automatic offer(input bic_instr_type x);
        x.pc = pc_q;
        x.next_pc = pc_q + 32'h4;
        x.reg_num[3] = 1'b0;
        pc_q = pc_q + 32'h4;
        instr <= x;
    endtask
    // Inverted idle fields, so a stale instruction never looks current
    task automatic idle();
        bic_instr_type t;
        t = bic_instr_type'(~instr);
        t.valid = 1'b0;
        instr <= t;
    endtask
endmodule // bic_stream_model
`default_nettype wire

/* File: verilog/bic_branch_it_ctrl.sv */
// Behaviour
// - Link branches write the following instruction's address into the link register.
// - Indirect branches with target bit 0 clear raise a usage fault instead.
// - Indirect destination is the target register value with bit 0 forced low.
// - Unconditional, link and in-block conditional branches reach sixteen megabytes.
// - Conditional branches outside a block reach only one megabyte.
// - Compare-zero jumps branch on zero or nonzero, flags untouched.
// - Compare-zero operand is R0 to R7, target 4 to 130 bytes forward.
// - No branch form modifies condition flags.
// - If-then prefix makes one to four following instructions conditional.
// - Base condition rules slot one; later slots take it or its inverse.
// - Breakpoint inside a block always executes, even if its condition fails.
// - Exceptions are accepted inside a block with return state saved.
// - Exception return resumes the interrupted block correctly.
`include "bic_params.svh"
`timescale 1ns/100ps
`default_nettype none
module bic_branch_it_ctrl
    import bic_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire bic_instr_type instr,
    input wire logic [3:0] flags,
    input wire logic exc_take,
    input wire logic exc_resume,
    input wire bic_it_type it_restore,
    output bic_it_type it_saved,
    output bic_result_type result,
    output logic it_active
);
    // Block state holds the slots still to run, the base condition and a
    // queue of else flags whose top bit belongs to the current slot; the
    // queue shifts once per block instruction, so no slot sees a later switch
    bic_state_type state_q;
    bic_state_type state_d;

    // Standard condition evaluation on the flag nibble
    function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
        logic n;
        logic z;
        logic cy;
        logic v;
        logic r;
        n = f[`BIC_FLAG_N];
        z = f[`BIC_FLAG_Z];
        cy = f[`BIC_FLAG_C];
        v = f[`BIC_FLAG_V];
        unique case (c[3:1])
            3'h0: r = z;
            3'h1: r = cy;
            3'h2: r = n;
            3'h3: r = v;
            3'h4: r = cy & ~z;
            3'h5: r = (n == v);
            3'h6: r = (n == v) & ~z;
            default: r = 1'b1;
        endcase
        // Odd codes invert, except always
        if (c[0] && c[3:1] != 3'h7) begin
            r = ~r;
        end
        return r;
    endfunction

    // Reach check for signed displacements
    function automatic logic in_reach(input logic [31:0] off, input logic far);
        logic signed [31:0] s;
        s = $signed(off);
        if (far) begin
            return (s >= -`BIC_FAR_REACH) && (s < `BIC_FAR_REACH);
        end
        return (s >= -`BIC_NEAR_REACH) && (s < `BIC_NEAR_REACH);
    endfunction

    // Block length from the lowest set mask bit, which ends the pattern
    function automatic logic [2:0] slot_count(input logic [3:0] m);
        logic [2:0] k;
        if (m[0]) begin
            k = `BIC_IT_MAX_SLOTS;
        end else if (m[1]) begin
            k = 3'h3;
        end else if (m[2]) begin
            k = 3'h2;
        end else begin
            k = 3'h1;
        end
        return k;
    endfunction

    // Else flags queued behind slot one, which always takes the base condition
    function automatic logic [3:0] else_load(input logic [3:0] m, input logic [3:0] c);
        logic [3:0] e;
        e = {1'b0, m[3:1]};
        // An always block never inverts, so stray switches are dropped
        if (c == `BIC_COND_ALWAYS) begin
            e = 4'h0;
        end
        return e;
    endfunction

    // Relative destination shared by the immediate and compare forms
    function automatic logic [31:0] rel_target(input logic [31:0] base, input logic [31:0] off);
        // Carry out of bit 31 wraps, as the address space does
        return base + off;
    endfunction

    // Forms that leave a return address behind
    function automatic logic is_link(input bic_op_type op);
        return (op == BIC_OP_BRANCH_LINK_IMM) || (op == BIC_OP_BRANCH_INDIRECT_LINK);
    endfunction

    logic slot_else;
    logic slot_cond;
    logic [3:0] eff_cond;
    logic cond_ok;
    logic in_block;

    // Current slot condition from block state
    // Registered state means a prefix never governs its own cycle
    always_comb begin
        in_block = (state_q.it.count != 3'h0);
        slot_else = state_q.it.else_bits[3];
        eff_cond = in_block ? (state_q.it.base_cond ^ {3'h0, slot_else}) : instr.cond;
        slot_cond = cond_pass(eff_cond, flags);
        // Outside a block only the conditional branch tests its own condition
        cond_ok = in_block ? slot_cond : 1'b1;
    end

    // Execute one instruction per valid cycle
    always_comb begin
        state_d = state_q;
        state_d.res = '0;
        // A return reloads the stacked block and ignores the offered instruction
        if (exc_resume) begin
            state_d.it = it_restore;
        end else if (instr.valid && !exc_take) begin
            state_d.res.valid = 1'b1;
            state_d.res.in_block = in_block;
            // Failed slots have no effect; breakpoint runs regardless
            state_d.res.executed = cond_ok || (instr.op == BIC_OP_BREAKPOINT);
            if (state_d.res.executed) begin
                unique case (instr.op)
                    BIC_OP_BRANCH_IMM, BIC_OP_BRANCH_LINK_IMM: begin
                        // Full reach applies whether or not a block is open
                        state_d.res.taken = in_reach(instr.offset, 1'b1);
                        state_d.res.target = rel_target(instr.pc, instr.offset);
                        if (is_link(instr.op)) begin
                            state_d.res.link_we = 1'b1;
                            state_d.res.link_value = instr.next_pc;
                        end
                    end
                    BIC_OP_BRANCH_COND: begin
                        // Longer reach only inside a block
                        state_d.res.taken = (in_block || cond_pass(instr.cond, flags))
                            && in_reach(instr.offset, in_block);
                        state_d.res.target = rel_target(instr.pc, instr.offset);
                    end
                    BIC_OP_BRANCH_INDIRECT, BIC_OP_BRANCH_INDIRECT_LINK: begin
                        if (!instr.reg_value[0]) begin
                            state_d.res.fault = 1'b1;
                        end else begin
                            state_d.res.taken = 1'b1;
                            state_d.res.target = {instr.reg_value[31:1], 1'b0};
                            // Relies on software never naming the program counter here
                            if (is_link(instr.op)) begin
                                state_d.res.link_we = 1'b1;
                                state_d.res.link_value = instr.next_pc;
                            end
                        end
                    end
                    BIC_OP_COMPARE_ZERO_JUMP, BIC_OP_COMPARE_NONZERO_JUMP: begin
                        // Flags are an input only; nothing here writes them
                        // Out-of-range forms fall through rather than fault
                        state_d.res.taken = ((instr.reg_value == 32'h0) ==
                            (instr.op == BIC_OP_COMPARE_ZERO_JUMP))
                            && (instr.reg_num <= `BIC_LOW_REG_MAX)
                            && (instr.offset >= `BIC_CZ_MIN)
                            && (instr.offset <= `BIC_CZ_MAX);
                        state_d.res.target = rel_target(instr.pc, instr.offset);
                    end
                    default: begin
                        // Other operations only consume their slot
                    end
                endcase
            end
            // Advance or load block state; a prefix inside a block only uses its slot
            if (instr.op == BIC_OP_IF_THEN_PREFIX && !in_block) begin
                state_d.it.base_cond = instr.cond;
                state_d.it.else_bits = else_load(instr.it_mask, instr.cond);
                state_d.it.count = slot_count(instr.it_mask);
            end else if (in_block) begin
                state_d.it.count = state_q.it.count - 3'h1;
                state_d.it.else_bits = {state_q.it.else_bits[2:0], 1'b0};
                if (state_q.it.count == 3'h1) begin
                    state_d.it = '0;
                end
            end
        end
    end

    // Block state survives exception entry untouched
    // Reset branch loads constants only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs come straight from the state flops
    assign result = state_q.res;
    assign it_saved = state_q.it;
    assign it_active = (state_q.it.count != 3'h0);
endmodule // bic_branch_it_ctrl
`default_nettype wire

/* File: verilog/bic_params.svh */
`ifndef BIC_PARAMS_SVH
`define BIC_PARAMS_SVH
// Register numbers and encodings
`define BIC_LINK_REG 4'he
`define BIC_PROG_COUNTER_REG 4'hf
`define BIC_LOW_REG_MAX 4'h7
// Reach limits in bytes
`define BIC_FAR_REACH 32'sh0100_0000
`define BIC_NEAR_REACH 32'sh0010_0000
`define BIC_CZ_MIN 32'h0000_0004
`define BIC_CZ_MAX 32'h0000_0082
// If-then block size
`define BIC_IT_MAX_SLOTS 3'h4
// Condition code for always
`define BIC_COND_ALWAYS 4'he
// Flag bit positions inside the flag nibble {n,z,c,v}
`define BIC_FLAG_N 3
`define BIC_FLAG_Z 2
`define BIC_FLAG_C 1
`define BIC_FLAG_V 0
`endif

/* File: verilog/bic_pkg.sv */
package bic_pkg;
    typedef enum logic [3:0] {
        BIC_OP_NONE = 4'h0,
        BIC_OP_BRANCH_IMM = 4'h1,
        BIC_OP_BRANCH_COND = 4'h2,
        BIC_OP_BRANCH_LINK_IMM = 4'h3,
        BIC_OP_BRANCH_INDIRECT = 4'h4,
        BIC_OP_BRANCH_INDIRECT_LINK = 4'h5,
        BIC_OP_COMPARE_ZERO_JUMP = 4'h6,
        BIC_OP_COMPARE_NONZERO_JUMP = 4'h7,
        BIC_OP_IF_THEN_PREFIX = 4'h8,
        BIC_OP_BREAKPOINT = 4'h9,
        BIC_OP_OTHER = 4'ha,
        BIC_OP_EXC_RETURN = 4'hb
    } bic_op_type;

    // One decoded instruction offered for execution
    typedef struct packed {
        logic valid;
        bic_op_type op;
        logic [31:0] pc;
        logic [31:0] next_pc;
        logic [3:0] cond;
        logic [31:0] offset;
        logic [3:0] reg_num;
        logic [31:0] reg_value;
        logic [3:0] it_mask;
    } bic_instr_type;

    // If-then state saved on exception and restored on return
    typedef struct packed {
        logic [2:0] count;
        logic [3:0] base_cond;
        logic [3:0] else_bits;
    } bic_it_type;

    // Result of one executed instruction
    typedef struct packed {
        logic valid;
        logic taken;
        logic [31:0] target;
        logic link_we;
        logic [31:0] link_value;
        logic fault;
        logic executed;
        logic in_block;
    } bic_result_type;

    typedef struct packed {
        bic_it_type it;
        bic_result_type res;
    } bic_state_type;
endpackage
